/* File: core/memzo_pkg.sv */
// Constants for the miscellaneous error mask and zone offset register bank.
// Assumes an 8-bit register port driven by the serial interface engine.
package memzo_pkg;

	// Register offsets on the internal register port
	localparam logic [7:0] MEMZO_ADDR_MISC_MASK = 8'hED;
	localparam logic [7:0] MEMZO_ADDR_ZONE1A    = 8'hEE;
	localparam logic [7:0] MEMZO_ADDR_ZONE2A    = 8'hEF;

	// Reset values
	localparam logic [7:0] MEMZO_RST_MISC_MASK  = 8'h3F;
	localparam logic [7:0] MEMZO_RST_ZONE_OFS   = 8'h00;

	// Implemented field widths; bits above read as zero
	localparam int MEMZO_MASK_W = 6;
	localparam int MEMZO_OFS_W  = 6;

	// Mask bit positions
	localparam int MEMZO_BIT_HOT_ONE  = 0;
	localparam int MEMZO_BIT_HOT_TWO  = 1;
	localparam int MEMZO_BIT_GP_EIGHT = 2;
	localparam int MEMZO_BIT_GP_NINE  = 3;
	localparam int MEMZO_BIT_CPU_ONE  = 4;
	localparam int MEMZO_BIT_CPU_TWO  = 5;

	// Default temperature word width, one degree per LSB
	localparam int MEMZO_TEMP_W = 8;

endpackage

/* File: core/memzo_temp_adjust.sv */
// Saturating adder for one temperature zone offset.
// Assumes signed two's complement temperature and offset, TEMP_W > OFS_W.
`timescale 1ns/1ps
module memzo_temp_adjust #(
	parameter int TEMP_W = 8,
	parameter int OFS_W  = 6
) (
	input  wire logic [TEMP_W-1:0] tempRaw,
	input  wire logic [OFS_W-1:0]  tempOffset,
	output logic      [TEMP_W-1:0] tempAdj
);

	logic [TEMP_W-1:0] ofsExt;
	logic [TEMP_W:0]   sumWide;

	// Sign extension and one guard bit so overflow is visible
	always_comb begin
		ofsExt  = {{(TEMP_W-OFS_W){tempOffset[OFS_W-1]}}, tempOffset};
		sumWide = {tempRaw[TEMP_W-1], tempRaw} + {ofsExt[TEMP_W-1], ofsExt};
		// Clamp rather than wrap: a wrapped hot reading would look cold
		if (sumWide[TEMP_W] != sumWide[TEMP_W-1]) begin
			if (sumWide[TEMP_W]) begin
				tempAdj = {1'b1, {(TEMP_W-1){1'b0}}};
			end else begin
				tempAdj = {1'b0, {(TEMP_W-1){1'b1}}};
			end
		end else begin
			tempAdj = sumWide[TEMP_W-1:0];
		end
	end

endmodule

/* File: core/memzo_top.sv */
// Miscellaneous error mask and zone 1a / 2a temperature offset registers.
// Assumes the serial interface engine and measurement engine share clk_sys.
// What this block does
// - Mask bit 0 set suppresses regulator hot one error events.
// - Mask bit 1 set suppresses regulator hot two error events.
// - Mask bit 2 set suppresses general input eight error events.
// - Mask bit 3 set suppresses general input nine error events.
// - Mask bit 4 set suppresses analog input seven core voltage limit events.
// - Mask bit 5 set suppresses analog input eight core voltage limit events.
// - Signed 6-bit offset is added to each zone 1a/2a measurement when taken.
// - Every consumer sees only the offset-corrected zone temperature.
// - Offset spans +31 to -32 degrees, one degree per LSB.
`timescale 1ns/1ps
module memzo_top
	import memzo_pkg::*;
#(
	parameter int TEMP_W = MEMZO_TEMP_W
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [7:0]        regAddr,
	input  wire logic              regWrEn,
	input  wire logic [7:0]        regWrData,
	input  wire logic              regRdEn,
	output logic      [7:0]        regRdData,
	input  wire logic              regulatorHotOneInputEvt,
	input  wire logic              regulatorHotTwoInputEvt,
	input  wire logic              generalInputEightEvt,
	input  wire logic              generalInputNineEvt,
	input  wire logic              analogInputSevenEvt,
	input  wire logic              analogInputEightEvt,
	output logic                   regulatorHotOneErr,
	output logic                   regulatorHotTwoErr,
	output logic                   generalInputEightErr,
	output logic                   generalInputNineErr,
	output logic                   analogInputSevenErr,
	output logic                   analogInputEightErr,
	input  wire logic [TEMP_W-1:0] zoneOneARaw,
	input  wire logic              zoneOneARawVld,
	input  wire logic [TEMP_W-1:0] zoneTwoARaw,
	input  wire logic              zoneTwoARawVld,
	output logic      [TEMP_W-1:0] zoneOneATemp,
	output logic                   zoneOneATempVld,
	output logic      [TEMP_W-1:0] zoneTwoATemp,
	output logic                   zoneTwoATempVld
);

	typedef struct packed {
		logic [MEMZO_MASK_W-1:0] mask;
		logic [MEMZO_OFS_W-1:0]  zoneOneAOffset;
		logic [MEMZO_OFS_W-1:0]  zoneTwoAOffset;
		logic [MEMZO_MASK_W-1:0] errOut;
		logic [TEMP_W-1:0]       zoneOneATemp;
		logic                    zoneOneAVld;
		logic [TEMP_W-1:0]       zoneTwoATemp;
		logic                    zoneTwoAVld;
		logic [7:0]              rdData;
	} memzo_state_t;

	memzo_state_t st_r;
	memzo_state_t st_nxt;

	logic [MEMZO_MASK_W-1:0] evIn;
	logic [TEMP_W-1:0]       zoneOneAAdj;
	logic [TEMP_W-1:0]       zoneTwoAAdj;

	assign evIn = {analogInputEightEvt, analogInputSevenEvt,
		generalInputNineEvt, generalInputEightEvt,
		regulatorHotTwoInputEvt, regulatorHotOneInputEvt};

	// One adder per zone, same arithmetic for both
	memzo_temp_adjust #(
		.TEMP_W (TEMP_W),
		.OFS_W  (MEMZO_OFS_W)
	) uZoneOneA (
		.tempRaw    (zoneOneARaw),
		.tempOffset (st_r.zoneOneAOffset),
		.tempAdj    (zoneOneAAdj)
	);

	memzo_temp_adjust #(
		.TEMP_W (TEMP_W),
		.OFS_W  (MEMZO_OFS_W)
	) uZoneTwoA (
		.tempRaw    (zoneTwoARaw),
		.tempOffset (st_r.zoneTwoAOffset),
		.tempAdj    (zoneTwoAAdj)
	);

	// Next state: register writes, event masking, temperature capture
	always_comb begin
		st_nxt = st_r;
		// Only the low six bits exist; upper write bits are dropped
		if (regWrEn) begin
			unique case (regAddr)
				MEMZO_ADDR_MISC_MASK: st_nxt.mask = regWrData[MEMZO_MASK_W-1:0];
				MEMZO_ADDR_ZONE1A: begin
					st_nxt.zoneOneAOffset = regWrData[MEMZO_OFS_W-1:0];
				end
				MEMZO_ADDR_ZONE2A: begin
					st_nxt.zoneTwoAOffset = regWrData[MEMZO_OFS_W-1:0];
				end
				default: ;
			endcase
		end
		// Masking uses the mask as it stood when the event arrived
		st_nxt.errOut[MEMZO_BIT_HOT_ONE] = evIn[MEMZO_BIT_HOT_ONE]
			& ~st_r.mask[MEMZO_BIT_HOT_ONE];
		st_nxt.errOut[MEMZO_BIT_HOT_TWO] = evIn[MEMZO_BIT_HOT_TWO]
			& ~st_r.mask[MEMZO_BIT_HOT_TWO];
		st_nxt.errOut[MEMZO_BIT_GP_EIGHT] = evIn[MEMZO_BIT_GP_EIGHT]
			& ~st_r.mask[MEMZO_BIT_GP_EIGHT];
		st_nxt.errOut[MEMZO_BIT_GP_NINE] = evIn[MEMZO_BIT_GP_NINE]
			& ~st_r.mask[MEMZO_BIT_GP_NINE];
		st_nxt.errOut[MEMZO_BIT_CPU_ONE] = evIn[MEMZO_BIT_CPU_ONE]
			& ~st_r.mask[MEMZO_BIT_CPU_ONE];
		st_nxt.errOut[MEMZO_BIT_CPU_TWO] = evIn[MEMZO_BIT_CPU_TWO]
			& ~st_r.mask[MEMZO_BIT_CPU_TWO];
		// The raw value never leaves the block; only the adjusted one is held
		st_nxt.zoneOneAVld = zoneOneARawVld;
		st_nxt.zoneTwoAVld = zoneTwoARawVld;
		if (zoneOneARawVld) begin
			st_nxt.zoneOneATemp = zoneOneAAdj;
		end
		if (zoneTwoARawVld) begin
			st_nxt.zoneTwoATemp = zoneTwoAAdj;
		end
		// Read data: reserved bits zero, unmapped offsets read zero
		if (regRdEn) begin
			unique case (regAddr)
				MEMZO_ADDR_MISC_MASK: st_nxt.rdData = {2'h0, st_r.mask};
				MEMZO_ADDR_ZONE1A: st_nxt.rdData = {2'h0, st_r.zoneOneAOffset};
				MEMZO_ADDR_ZONE2A: st_nxt.rdData = {2'h0, st_r.zoneTwoAOffset};
				default: st_nxt.rdData = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r                <= '0;
			st_r.mask           <= MEMZO_RST_MISC_MASK[MEMZO_MASK_W-1:0];
			st_r.zoneOneAOffset <= MEMZO_RST_ZONE_OFS[MEMZO_OFS_W-1:0];
			st_r.zoneTwoAOffset <= MEMZO_RST_ZONE_OFS[MEMZO_OFS_W-1:0];
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign regRdData            = st_r.rdData;
	assign regulatorHotOneErr   = st_r.errOut[MEMZO_BIT_HOT_ONE];
	assign regulatorHotTwoErr   = st_r.errOut[MEMZO_BIT_HOT_TWO];
	assign generalInputEightErr = st_r.errOut[MEMZO_BIT_GP_EIGHT];
	assign generalInputNineErr  = st_r.errOut[MEMZO_BIT_GP_NINE];
	assign analogInputSevenErr  = st_r.errOut[MEMZO_BIT_CPU_ONE];
	assign analogInputEightErr  = st_r.errOut[MEMZO_BIT_CPU_TWO];
	assign zoneOneATemp         = st_r.zoneOneATemp;
	assign zoneOneATempVld      = st_r.zoneOneAVld;
	assign zoneTwoATemp         = st_r.zoneTwoATemp;
	assign zoneTwoATempVld      = st_r.zoneTwoAVld;

	// Checking helpers: independent integer model of the clamped sum
	function automatic int refAdj(input logic [TEMP_W-1:0] raw,
		input logic [MEMZO_OFS_W-1:0] ofs);
		int s;
		s = int'($signed(raw)) + int'($signed(ofs));
		if (s > (2 ** (TEMP_W - 1)) - 1) begin
			s = (2 ** (TEMP_W - 1)) - 1;
		end
		if (s < -(2 ** (TEMP_W - 1))) begin
			s = -(2 ** (TEMP_W - 1));
		end
		return s;
	endfunction

	logic [MEMZO_MASK_W-1:0] maskNow;
	int                      refOne;
	int                      refTwo;
	assign maskNow = st_r.mask;
	assign refOne  = refAdj(zoneOneARaw, st_r.zoneOneAOffset);
	assign refTwo  = refAdj(zoneTwoARaw, st_r.zoneTwoAOffset);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	AST_HOT_ONE_MASK: assert property (
		regulatorHotOneInputEvt |=> regulatorHotOneErr ==
			!$past(maskNow[MEMZO_BIT_HOT_ONE]))
		else $error("regulator hot one masking wrong");
	AST_HOT_TWO_MASK: assert property (
		regulatorHotTwoInputEvt && maskNow[MEMZO_BIT_HOT_TWO]
			|=> !regulatorHotTwoErr)
		else $error("regulator hot two event not masked");
	AST_GP_EIGHT_MASK: assert property (
		generalInputEightEvt |=> generalInputEightErr ==
			!$past(maskNow[MEMZO_BIT_GP_EIGHT]))
		else $error("general input eight masking wrong");
	AST_GP_NINE_MASK: assert property (
		$rose(generalInputNineErr) |-> $past(generalInputNineEvt)
			&& !$past(maskNow[MEMZO_BIT_GP_NINE]))
		else $error("general input nine error without cause");
	AST_CPU_ONE_MASK: assert property (
		analogInputSevenEvt && !maskNow[MEMZO_BIT_CPU_ONE]
			|=> analogInputSevenErr)
		else $error("analog input seven event lost");
	AST_CPU_TWO_MASK: assert property (
		analogInputEightEvt |=> analogInputEightErr ==
			!$past(maskNow[MEMZO_BIT_CPU_TWO]))
		else $error("analog input eight masking wrong");
	AST_ZONE_ONE_ADD: assert property (
		zoneOneARawVld |=> zoneOneATempVld
			&& int'($signed(zoneOneATemp)) == $past(refOne))
		else $error("zone 1a adjusted value wrong");
	AST_ZONE_TWO_ADD: assert property (
		zoneTwoARawVld |=> zoneTwoATempVld
			&& int'($signed(zoneTwoATemp)) == $past(refTwo))
		else $error("zone 2a adjusted value wrong or wrapped");
	AST_ZONE_HOLD: assert property (
		!zoneOneARawVld |=> !zoneOneATempVld && $stable(zoneOneATemp))
		else $error("zone 1a temperature changed without measurement");
	AST_OFS_WRITE: assert property (
		regWrEn && regAddr == MEMZO_ADDR_ZONE1A ##1 regRdEn
			&& regAddr == MEMZO_ADDR_ZONE1A && !regWrEn
			|=> regRdData == {2'h0,
				$past(regWrData[MEMZO_OFS_W-1:0], 2)})
		else $error("zone 1a offset readback wrong");
	AST_RES_ZERO: assert property (
		regRdEn |=> regRdData[7:6] == 2'h0)
		else $error("reserved bits read non-zero");

	COV_MASKED_HOT: cover property (
		regulatorHotOneInputEvt && maskNow[MEMZO_BIT_HOT_ONE]);
	COV_PASS_CPU: cover property (
		analogInputSevenEvt && !maskNow[MEMZO_BIT_CPU_ONE]);
	COV_SAT_HIGH: cover property (zoneOneARawVld
		&& refOne == (2 ** (TEMP_W - 1)) - 1);
	COV_NEG_OFS: cover property (zoneTwoARawVld
		&& st_r.zoneTwoAOffset[MEMZO_OFS_W-1]);

endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the error mask and zone offset register bank.
// Assumes the design files are compiled first; inputs move at falling edges.
`timescale 1ns/1ps
module tb;
	import memzo_pkg::*;
	logic       clk_sys;
	logic       rst_n;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrEn;
	logic       regRdEn;
	wire  [7:0] regRdData;
	logic [5:0] evt;
	wire  [5:0] err;
	logic [7:0] r1;
	logic [7:0] r2;
	logic       v1;
	logic       v2;
	wire  [7:0] t1;
	wire  [7:0] t2;
	wire        tv1;
	wire        tv2;
	int         n_mismatch;
	int         num_checks;
	int         cyc;
	int         seed;
	logic [7:0] m;
	logic [7:0] e;

	memzo_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdData), .regulatorHotOneInputEvt(evt[0]),
		.regulatorHotTwoInputEvt(evt[1]), .generalInputEightEvt(evt[2]),
		.generalInputNineEvt(evt[3]), .analogInputSevenEvt(evt[4]),
		.analogInputEightEvt(evt[5]), .regulatorHotOneErr(err[0]),
		.regulatorHotTwoErr(err[1]), .generalInputEightErr(err[2]),
		.generalInputNineErr(err[3]), .analogInputSevenErr(err[4]),
		.analogInputEightErr(err[5]), .zoneOneARaw(r1), .zoneOneARawVld(v1),
		.zoneTwoARaw(r2), .zoneTwoARawVld(v2), .zoneOneATemp(t1),
		.zoneOneATempVld(tv1), .zoneTwoATemp(t2), .zoneTwoATempVld(tv2));

	// Expected corrected temperature, clamped rather than wrapped
	function automatic logic [7:0] sat(input logic [7:0] raw,
		input logic [5:0] ofs);
		int s;
		s = int'($signed(raw)) + int'($signed(ofs));
		if (s > 127) s = 127;
		if (s < -128) s = -128;
		return s[7:0];
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// One-cycle strobes; each task starts on a fresh falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys) begin
			regAddr = a;
			regWrData = d;
			regWrEn = 1'b1;
		end
		@(negedge clk_sys) regWrEn = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys) begin
			regAddr = a;
			regRdEn = 1'b1;
		end
		@(negedge clk_sys) regRdEn = 1'b0;
		chk(regRdData, exp);
	endtask

	// Write then read in the very next cycle, no idle edge between
	task automatic wrRd(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys) begin
			regAddr = a;
			regWrData = d;
			regWrEn = 1'b1;
		end
		@(negedge clk_sys) begin
			regWrEn = 1'b0;
			regRdEn = 1'b1;
		end
		@(negedge clk_sys) regRdEn = 1'b0;
		chk(regRdData, {2'h0, d[5:0]});
	endtask

	// Error events pass one cycle late unless their mask bit is set
	task automatic ev(input logic [7:0] ev_in, input logic [7:0] msk);
		@(negedge clk_sys) evt = ev_in[5:0];
		@(negedge clk_sys) evt = 6'h00;
		chk({2'h0, err}, {2'h0, ev_in[5:0] & ~msk[5:0]});
	endtask

	// Both zones measured together; junk in bits 7:6 must not matter
	task automatic temp(input logic [7:0] ra, input logic [7:0] rb,
		input logic [5:0] oa, input logic [5:0] ob);
		wr(MEMZO_ADDR_ZONE1A, 8'($random(seed)) & 8'hC0 | {2'h0, oa});
		wr(MEMZO_ADDR_ZONE2A, 8'($random(seed)) & 8'hC0 | {2'h0, ob});
		@(negedge clk_sys) begin
			r1 = ra;
			r2 = rb;
			v1 = 1'b1;
			v2 = 1'b1;
		end
		@(negedge clk_sys) begin
			v1 = 1'b0;
			v2 = 1'b0;
		end
		chk(t1, sat(ra, oa));
		chk(t2, sat(rb, ob));
		chk({6'h00, tv1, tv2}, 8'h03);
		@(negedge clk_sys);
		chk({6'h00, tv1, tv2}, 8'h00);
		// The corrected value must stand until the next measurement
		chk(t1, sat(ra, oa));
		chk(t2, sat(rb, ob));
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Hang guard, far above the roughly 720 cycles the run needs
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	initial begin
		seed = 32'hDE8B;
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		evt = 6'h00;
		r1 = 8'h00;
		r2 = 8'h00;
		v1 = 1'b0;
		v2 = 1'b0;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys) rst_n = 1'b1;
		rd(MEMZO_ADDR_MISC_MASK, 8'h3F);
		rd(MEMZO_ADDR_ZONE1A, 8'h00);
		rd(MEMZO_ADDR_ZONE2A, 8'h00);
		ev(8'h3F, 8'h3F);
		wr(8'hEC, 8'hFF);
		rd(8'hEC, 8'h00);
		wr(MEMZO_ADDR_MISC_MASK, 8'hC0);
		rd(MEMZO_ADDR_MISC_MASK, 8'h00);
		ev(8'h3F, 8'h00);
		wrRd(MEMZO_ADDR_ZONE1A, 8'hFF);
		// Each mask bit cleared alone lets only its own event through
		for (int i = 0; i < 6; i++) begin
			m = 8'h3F ^ (8'h01 << i);
			wr(MEMZO_ADDR_MISC_MASK, m);
			ev(8'h3F, m);
		end
		for (int i = 0; i < 40; i++) begin
			m = 8'($random(seed));
			e = 8'($random(seed));
			wr(MEMZO_ADDR_MISC_MASK, m);
			rd(MEMZO_ADDR_MISC_MASK, m & 8'h3F);
			ev(e, m);
		end
		// Range ends of offset and temperature
		temp(8'h81, 8'h81, 6'h3E, 6'h3E);
		temp(8'h7F, 8'h80, 6'h1F, 6'h20);
		temp(8'h00, 8'h00, 6'h1F, 6'h20);
		rd(MEMZO_ADDR_ZONE2A, 8'h20);
		for (int i = 0; i < 40; i++) begin
			wrRd(MEMZO_ADDR_ZONE1A, 8'($random(seed)));
			temp(8'($random(seed)), 8'($random(seed)),
				6'($random(seed)), 6'($random(seed)));
		end
		// Reset in mid-run must bring back every default
		@(negedge clk_sys) rst_n = 1'b0;
		@(negedge clk_sys);
		chk(t1, 8'h00);
		chk(t2, 8'h00);
		@(negedge clk_sys) rst_n = 1'b1;
		rd(MEMZO_ADDR_MISC_MASK, 8'h3F);
		rd(MEMZO_ADDR_ZONE1A, 8'h00);
		rd(MEMZO_ADDR_ZONE2A, 8'h00);
		ev(8'h3F, 8'h3F);
		results();
	end
endmodule
